// [srmq_pkg.sv]
// Shared constants and types for the shift-right-algebraic datapath
package srmq_pkg;

  // Word width of the fixed-point datapath
  localparam int WORD_W = 32;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SRC    = 8'h04;
  localparam logic [7:0] OFF_AMOUNT = 8'h08;
  localparam logic [7:0] OFF_INSTR  = 8'h0C;
  localparam logic [7:0] OFF_DEST   = 8'h10;
  localparam logic [7:0] OFF_AUXQ   = 8'h14;
  localparam logic [7:0] OFF_FLAGS  = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // Control register fields and reset value
  localparam int          CTRL_LEGACY_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // Flags register fields
  localparam int FLAGS_CARRY_BIT = 0;
  localparam int FLAGS_SO_BIT    = 1;
  localparam int FLAGS_CR0_LSB   = 4;

  // Status register fields
  localparam int STATUS_DONE_BIT    = 0;
  localparam int STATUS_ILLEGAL_BIT = 1;

  // Instruction fields, big-endian bit 0 is the word's MSB
  localparam int PRIMARY_MSB = 31;
  localparam int PRIMARY_LSB = 26;
  localparam int IMM_MSB     = 15;
  localparam int IMM_LSB     = 11;
  localparam int EXT_MSB     = 10;
  localparam int EXT_LSB     = 1;
  localparam int RECORD_POS  = 0;

  // Opcode values
  localparam logic [5:0] PRIMARY_OP = 6'h1F;
  localparam logic [9:0] EXT_IMM    = 10'h3B8;
  localparam logic [9:0] EXT_REG    = 10'h398;

  // Shift-amount register fields: bits 27-31 and bit 26
  localparam int AMT_MSB       = 4;
  localparam int AMT_LSB       = 0;
  localparam int AMT_FORCE_BIT = 5;

  // Datapath answer
  typedef struct packed {
    logic [31:0] dest;
    logic [31:0] aux_quotient;
    logic        carry_bit;
  } srmq_result_type;

  // Condition field 0, most significant first
  typedef struct packed {
    logic less_than_flag;
    logic greater_than_flag;
    logic equal_flag;
    logic summary_ovf;
  } srmq_cr0_type;

endpackage

// [srmq_core.sv]
// Rotate, mask, merge and carry datapath
`timescale 1ns/1ps
module srmq_core
  import srmq_pkg::*;
(
  input  wire logic [31:0]     src_in,
  input  wire logic [4:0]      amount_in,
  input  wire logic            force_zero_in,
  output srmq_result_type      result_out
);

  // Rotate left by 32 minus n equals rotate right by n, also for n of 0
  function automatic logic [31:0] rot_right(input logic [31:0] x,
                                            input logic [4:0]  n);
    logic [63:0] d;
    d = {x, x} >> n;
    return d[31:0];
  endfunction

  // n zeros then 32 minus n ones, MSB first
  function automatic logic [31:0] lead_zero_mask(input logic [4:0] n);
    return 32'hFFFF_FFFF >> n;
  endfunction

  logic [31:0] rotated;
  logic [31:0] mask;
  logic [31:0] sign_word;

  // Rotated source
  assign rotated = rot_right(src_in, amount_in);

  // Mask; bit 26 of the amount word wipes it out
  assign mask = force_zero_in ? 32'h0000_0000
                              : lead_zero_mask(amount_in);

  // Sign word is the source sign bit copied everywhere
  assign sign_word = {32{src_in[31]}};

  // Merge, quotient copy and carry
  assign result_out.dest = (rotated & mask) | (sign_word & ~mask);
  assign result_out.aux_quotient = rotated;
  assign result_out.carry_bit = (|(rotated & ~mask)) & src_in[31];

endmodule

// [srmq_top.sv]
// APB-reached shift-right-algebraic unit with quotient register
`timescale 1ns/1ps
module srmq_top
  import srmq_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic      [31:0] dest_reg_out,
  output logic      [31:0] aux_quotient_reg_out,
  output logic             carry_bit_out,
  output srmq_cr0_type     cr0_out,
  output logic             done_out,
  output logic             illegal_out
);

  // Register map, byte addresses:
  //   0x00 control; bit 0 enables the legacy instructions
  //   0x04 source operand
  //   0x08 shift amount; bits 4:0 amount, bit 5 empties the mask in the register form
  //   0x0C instruction; each write is one issue attempt
  //   0x10 destination result, read only
  //   0x14 quotient register, read only
  //   0x18 flags; bit 0 carry, bit 1 summary overflow
  //        bits 7:4 condition field 0, read only
  //   0x1C status; bit 0 done, bit 1 illegal, write one to clear
  // Writes to read-only words or bits are dropped without error;
  // only an address outside the map answers with an error.
  // Every access, mapped or not, answers after exactly one cycle,
  // so the bus never stalls on this unit.

  // One issue, cycle by cycle:
  //   setup cycle   instruction address and word on the bus
  //   access cycle  pready high, decode and datapath settle
  //   closing edge  result, quotient and carry load, field 0 too if record is set
  //   next cycle    done pulses once, status done is set
  // Operands are the register contents at the closing edge, so
  // software must load source and amount before the instruction.
  // There is no pipelining: one instruction per bus write, and the
  // results stand until the next legal issue.

  // Software-visible state
  logic [31:0]     ctrl;
  logic [31:0]     source_reg;
  logic [31:0]     shift_amount_reg;
  logic [31:0]     instr;
  logic            summary_ovf;
  logic            done_flag;

  // Access-phase qualifiers
  logic            setup_phase;
  logic            access_done;
  logic            wr_commit;
  logic            addr_known;

  // Per-register write strobes
  logic            wr_ctrl;
  logic            wr_src;
  logic            wr_amount;
  logic            wr_instr;
  logic            wr_flags;
  logic            wr_status;

  // Decode of the word being written to the instruction register
  logic [5:0]      dec_primary;
  logic [9:0]      dec_ext;
  logic [4:0]      dec_imm;
  logic            dec_record;
  logic            dec_is_imm;
  logic            dec_is_reg;
  logic            dec_legal;
  logic            legacy_en;
  logic            exec_go;
  logic            exec_bad;

  // Datapath operands and answer
  logic [4:0]      amount_sel;
  logic            force_zero;
  srmq_result_type core_result;

  // Condition field built from the new destination
  srmq_cr0_type    next_cr0;
  logic [31:0]     next_rdata;

  // APB phase decode
  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_out;
  assign wr_commit   = access_done & pwrite_in;

  // Only whole word addresses match; a byte offset inside a word is
  // treated as unmapped.
  // Address map check, used only by the error answer, not the read mux
  assign addr_known = (paddr_in == OFF_CTRL)   |
                      (paddr_in == OFF_SRC)    |
                      (paddr_in == OFF_AMOUNT) |
                      (paddr_in == OFF_INSTR)  |
                      (paddr_in == OFF_DEST)   |
                      (paddr_in == OFF_AUXQ)   |
                      (paddr_in == OFF_FLAGS)  |
                      (paddr_in == OFF_STATUS);

  // Strobes fire only in the one cycle that pready is high, so a
  // transfer can never write its register twice.
  // Write strobes only at the edge the master samples pready
  assign wr_ctrl   = wr_commit & (paddr_in == OFF_CTRL);
  assign wr_src    = wr_commit & (paddr_in == OFF_SRC);
  assign wr_amount = wr_commit & (paddr_in == OFF_AMOUNT);
  assign wr_instr  = wr_commit & (paddr_in == OFF_INSTR);
  assign wr_flags  = wr_commit & (paddr_in == OFF_FLAGS);
  assign wr_status = wr_commit & (paddr_in == OFF_STATUS);

  // The instruction word counts bit 0 as its most significant bit.
  // The package positions are already converted to vector indices,
  // so primary sits in 31:26, extended code in 10:1, record in 0.
  // Decode looks at the bus word, not the stored copy, so an issue
  // acts on the instruction in the same cycle that it is written.
  // Field extraction from the incoming instruction word
  assign dec_primary = pwdata_in[PRIMARY_MSB:PRIMARY_LSB];
  assign dec_ext     = pwdata_in[EXT_MSB:EXT_LSB];
  assign dec_imm     = pwdata_in[IMM_MSB:IMM_LSB];
  assign dec_record  = pwdata_in[RECORD_POS];

  // Any other extended code under the same primary opcode is left
  // to the refusal path below.
  // Both forms share the primary opcode
  assign dec_is_imm = (dec_primary == PRIMARY_OP) &
                      (dec_ext == EXT_IMM);
  assign dec_is_reg = (dec_primary == PRIMARY_OP) &
                      (dec_ext == EXT_REG);
  assign dec_legal  = dec_is_imm | dec_is_reg;

  // The gate is applied after decode so that a disabled unit still
  // reports the attempt through the illegal flag.
  // Variant gate: with legacy mode off, both opcodes count as illegal
  assign legacy_en = ctrl[CTRL_LEGACY_BIT];
  assign exec_go   = wr_instr & dec_legal & legacy_en;
  assign exec_bad  = wr_instr & ~(dec_legal & legacy_en);

  // The register form reads only the low six bits of the amount
  // word; higher bits are kept for read-back but never used.
  // Amount source: immediate field or low bits of the amount register
  assign amount_sel = dec_is_imm ? dec_imm
                    : shift_amount_reg[AMT_MSB:AMT_LSB];

  // An immediate issue ignores bit 5 of the amount word even if it
  // was left set by an earlier register-form issue.
  // The force bit only exists for the register form
  assign force_zero = dec_is_reg &
                      shift_amount_reg[AMT_FORCE_BIT];

  // The datapath is purely combinational; its answer is captured
  // only on a legal issue, so its value at other times never
  // reaches a port.
  // Rotate, mask, merge and carry
  srmq_core u_core (
    .src_in        (source_reg),
    .amount_in     (amount_sel),
    .force_zero_in (force_zero),
    .result_out    (core_result)
  );

  // Field 0 is built from the value about to be loaded, not from
  // the destination register, which still holds the old result.
  // A negative result gives 0x8 with summary overflow clear.
  // Signed compare of the new destination against zero
  assign next_cr0.less_than_flag    = core_result.dest[31];
  assign next_cr0.greater_than_flag = ~core_result.dest[31] &
                                      (|core_result.dest);
  assign next_cr0.equal_flag        = ~(|core_result.dest);
  // Summary overflow is copied, never raised here
  assign next_cr0.summary_ovf       = summary_ovf;

  // Reads are taken from the setup cycle and answered one cycle
  // later, so a read straight after a write sees the new value.
  // Read mux; unmapped addresses read as zero and flag an error
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr_in)
      OFF_CTRL:   next_rdata = ctrl;
      OFF_SRC:    next_rdata = source_reg;
      OFF_AMOUNT: next_rdata = shift_amount_reg;
      OFF_INSTR:  next_rdata = instr;
      OFF_DEST:   next_rdata = dest_reg_out;
      OFF_AUXQ:   next_rdata = aux_quotient_reg_out;
      OFF_FLAGS: begin
        next_rdata[FLAGS_CARRY_BIT] = carry_bit_out;
        next_rdata[FLAGS_SO_BIT]    = summary_ovf;
        next_rdata[FLAGS_CR0_LSB +: 4] = cr0_out;
      end
      OFF_STATUS: begin
        next_rdata[STATUS_DONE_BIT]    = done_flag;
        next_rdata[STATUS_ILLEGAL_BIT] = illegal_out;
      end
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  // Error and read data stand only while pready is high and are
  // zero otherwise, which keeps stale data off an idle bus.
  // APB answer: one fixed wait-free access phase, all from flops.
  // Registering pready costs nothing since setup always precedes access.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup_phase;
      pslverr_out <= setup_phase & ~addr_known;
      prdata_out  <= setup_phase ? next_rdata : 32'h0000_0000;
    end
  end

  // Control keeps only the enable bit; the other bits read as zero
  // whatever software writes to them.
  // Plain configuration and operand registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl             <= CTRL_RESET;
      source_reg       <= 32'h0000_0000;
      shift_amount_reg <= 32'h0000_0000;
      instr            <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata_in & CTRL_RESET;
      end
      if (wr_src) begin
        source_reg <= pwdata_in;
      end
      if (wr_amount) begin
        shift_amount_reg <= pwdata_in;
      end
      if (wr_instr) begin
        instr <= pwdata_in;
      end
    end
  end

  // A refused issue leaves both words untouched, so software can
  // still read the last good result after an illegal attempt.
  // Destination and quotient update together on a legal issue
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dest_reg_out         <= 32'h0000_0000;
      aux_quotient_reg_out <= 32'h0000_0000;
    end else if (exec_go) begin
      dest_reg_out         <= core_result.dest;
      aux_quotient_reg_out <= core_result.aux_quotient;
    end
  end

  // Carry is the only exception-register bit that an issue touches;
  // overflow is never raised by these instructions.
  // Carry follows every legal issue of either form, record bit or not.
  // Software may also load it, but an issue in the same cycle wins.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      carry_bit_out <= 1'b0;
    end else if (exec_go) begin
      carry_bit_out <= core_result.carry_bit;
    end else if (wr_flags) begin
      carry_bit_out <= pwdata_in[FLAGS_CARRY_BIT];
    end
  end

  // Software owns this bit entirely; an issue only copies it into
  // field 0 and never changes it.
  // Summary overflow is only ever set by software; the unit has no
  // overflow condition of its own
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      summary_ovf <= 1'b0;
    end else if (wr_flags) begin
      summary_ovf <= pwdata_in[FLAGS_SO_BIT];
    end
  end

  // The record bit is taken from the bus word of the issue itself,
  // so each issue decides alone whether field 0 moves.
  // Condition field 0 changes only when the record bit is set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cr0_out <= '0;
    end else if (exec_go & dec_record) begin
      cr0_out <= next_cr0;
    end
  end

  // A refused issue gives no pulse, so the pipeline can tell the
  // two outcomes apart without reading the status word.
  // One-cycle completion pulse for the surrounding pipeline
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= exec_go;
    end
  end

  // Software polls this word when it cannot watch the done pulse.
  // Sticky done flag; a new issue beats a write-one-to-clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_flag <= 1'b0;
    end else if (exec_go) begin
      done_flag <= 1'b1;
    end else if (wr_status & pwdata_in[STATUS_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  // With the legacy enable cleared both opcodes are refused here,
  // exactly as an unknown opcode would be.
  // Sticky illegal flag; a refused issue beats a write-one-to-clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      illegal_out <= 1'b0;
    end else if (exec_bad) begin
      illegal_out <= 1'b1;
    end else if (wr_status & pwdata_in[STATUS_ILLEGAL_BIT]) begin
      illegal_out <= 1'b0;
    end
  end

endmodule

// [srmq_ref.sv]
// Reference model of the rotate, mask, merge and carry datapath
`timescale 1ns/1ps
module srmq_ref
  import srmq_pkg::*;
(
  input  wire logic [31:0] src_in,
  input  wire logic [4:0]  n_in,
  input  wire logic        zero_in,
  output srmq_result_type  exp_out
);
  logic [63:0] both;
  logic [31:0] msk;
  // Rotating right by N is the same as rotating left by 32 minus N
  assign both = {src_in, src_in} >> n_in;
  // N zeros then ones; forcing gives no ones at all
  assign msk = zero_in ? 32'h0000_0000 : 32'hFFFF_FFFF >> n_in;
  // Quotient takes the unmerged word, destination the merge
  assign exp_out.aux_quotient = both[31:0];
  assign exp_out.dest = (both[31:0] & msk) | ({32{src_in[31]}} & ~msk);
  assign exp_out.carry_bit = src_in[31] & |(both[31:0] & ~msk);
endmodule

// [srmq_chk.sv]
// Checker of issue results seen at the top ports
`timescale 1ns/1ps
module srmq_chk
  import srmq_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         rst_in,
  input wire logic         psel_in,
  input wire logic         penable_in,
  input wire logic         pwrite_in,
  input wire logic [7:0]   paddr_in,
  input wire logic [31:0]  pwdata_in,
  input wire logic         pready_out,
  input wire logic [31:0]  dest_reg_out,
  input wire logic [31:0]  aux_quotient_reg_out,
  input wire logic         carry_bit_out,
  input wire srmq_cr0_type cr0_out,
  input wire logic         done_out,
  input wire logic         illegal_out
);
  logic [31:0] src;
  logic [31:0] amt;
  logic        leg;
  logic        so;
  // Bus write decode and the expected datapath answer
  wire        wr  = psel_in & penable_in & pready_out & pwrite_in;
  wire        iss = wr && paddr_in == OFF_INSTR;
  wire [9:0]  ext = pwdata_in[EXT_MSB:EXT_LSB];
  wire        rf  = ext == EXT_REG;
  wire        ok  = iss && leg && (ext == EXT_IMM || rf) &&
                    pwdata_in[PRIMARY_MSB:PRIMARY_LSB] == PRIMARY_OP;
  wire [4:0]  n   = rf ? amt[AMT_MSB:AMT_LSB] : pwdata_in[IMM_MSB:IMM_LSB];
  wire [31:0] msk = (rf && amt[AMT_FORCE_BIT]) ? '0 : 32'hFFFF_FFFF >> n;
  wire [31:0] rot = (src >> n) | (src << (6'h20 - n));
  wire [31:0] mrg = (rot & msk) | ({32{src[31]}} & ~msk);
  wire        cy  = |(rot & ~msk) & src[31];
  wire [3:0]  ecr = {mrg[31], !mrg[31] && |mrg, ~|mrg, so};
  // Shadow copies of the operands, kept as software writes them
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src <= '0;
      amt <= '0;
      leg <= 1'b1;
      so  <= 1'b0;
    end else if (wr) begin
      if (paddr_in == OFF_SRC) src <= pwdata_in;
      if (paddr_in == OFF_AMOUNT) amt <= pwdata_in;
      if (paddr_in == OFF_CTRL) leg <= pwdata_in[CTRL_LEGACY_BIT];
      if (paddr_in == OFF_FLAGS) so <= pwdata_in[FLAGS_SO_BIT];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_dest_merge:
    assert property (ok |=> dest_reg_out == $past(mrg))
    else $error("dest differs from merge");
  a_aux_rotated:
    assert property (ok |=> aux_quotient_reg_out == $past(rot))
    else $error("quotient differs from rotation");
  a_carry_calc:
    assert property (ok |=> carry_bit_out == $past(cy))
    else $error("carry wrong");
  a_cr0_record:
    assert property (ok && pwdata_in[RECORD_POS] |=> cr0_out == $past(ecr))
    else $error("cr0 wrong after record");
  a_cr0_keep:
    assert property (ok && !pwdata_in[RECORD_POS] |=> $stable(cr0_out))
    else $error("cr0 changed without record");
  a_done_pulse:
    assert property (ok |=> done_out ##1 !done_out)
    else $error("done not a single pulse");
  a_refuse_bad:
    assert property (iss && !ok |=>
      illegal_out && !done_out && $stable(dest_reg_out))
    else $error("refused issue had effect");
  a_result_hold:
    assert property (!ok |=> $stable(aux_quotient_reg_out))
    else $error("quotient changed without issue");
endmodule

bind srmq_top srmq_chk u_chk (
  .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .dest_reg_out, .aux_quotient_reg_out,
  .carry_bit_out, .cr0_out, .done_out, .illegal_out
);

// [srmq_top_tb.sv]
// Testbench issuing both shift forms over the register bus
`timescale 1ns/1ps
module srmq_top_tb
  import srmq_pkg::*;
;
  logic            clk_in     = 1'b0;
  logic            rst_in     = 1'b1;
  logic            psel_in    = 1'b0;
  logic            penable_in = 1'b0;
  logic            pwrite_in  = 1'b0;
  logic [7:0]      paddr_in   = 8'h00;
  logic [31:0]     pwdata_in  = 32'h0000_0000;
  logic [31:0]     prdata_out, dest_reg_out, aux_quotient_reg_out;
  logic            pready_out, pslverr_out, carry_bit_out;
  logic            done_out, illegal_out, er;
  srmq_cr0_type    cr0_out, ecr;
  srmq_result_type exp;
  logic [31:0]     rsrc, ramt, rins, rd, prev;
  int              mismatches = 0;
  int              compares   = 0;
  // Operand table: immediate and register forms, edge amounts
  logic [31:0] t_src [8] = '{32'h9000_3000, 32'hB004_3000, 32'h9000_3000,
    32'hB004_3000, 32'h8000_0001, 32'h8000_0001, 32'h7FFF_FFFF,
    32'h1234_5678};
  logic [31:0] t_amt [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0024,
    32'h0000_0004, 32'h0000_0020, 32'h0000_0000, 32'h0000_003F,
    32'h0000_000F};
  logic [31:0] t_ins [8] = '{32'h7C00_2770, 32'h7C00_2771, 32'h7C00_0730,
    32'h7C00_0731, 32'h7C00_0771, 32'h7C00_F770, 32'h7C00_0731,
    32'h7C00_0731};

  always #10 clk_in = ~clk_in;

  srmq_top DUT (
    .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .dest_reg_out,
    .aux_quotient_reg_out, .carry_bit_out, .cr0_out, .done_out,
    .illegal_out
  );
  // Immediate form ignores the force bit of the amount register
  srmq_ref u_ref (
    .src_in  (rsrc),
    .n_in    (rins[10:1] == EXT_IMM ? rins[15:11] : ramt[4:0]),
    .zero_in (rins[10:1] == EXT_REG && ramt[5]),
    .exp_out (exp)
  );

  task automatic chk(input string nm, input logic [31:0] got, want);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, want, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One bus transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    if (i == 16) begin
      mismatches++;
      end_sim();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic issue(input logic [31:0] s, a, ins);
    rsrc = s;
    ramt = a;
    rins = ins;
    apb(1'b1, OFF_SRC, s);
    apb(1'b1, OFF_AMOUNT, a);
    apb(1'b1, OFF_INSTR, ins);
  endtask

  initial begin
    ecr = '0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk("ctrl", rd, CTRL_RESET);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped_err", er, 32'h0000_0001);
    chk("unmapped_data", rd, 32'h0000_0000);
    apb(1'b1, OFF_DEST, 32'hFFFF_FFFF);
    apb(1'b1, OFF_FLAGS, 32'h0000_0002);
    apb(1'b0, OFF_DEST, 32'h0000_0000);
    chk("dest_ro", rd, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      issue(t_src[c], t_amt[c], t_ins[c]);
      if (t_ins[c][RECORD_POS])
        ecr = {exp.dest[31], !exp.dest[31] && |exp.dest, ~|exp.dest, 1'b1};
      chk("done", done_out, 32'h0000_0001);
      chk("dest", dest_reg_out, exp.dest);
      chk("auxq", aux_quotient_reg_out, exp.aux_quotient);
      chk("carry", carry_bit_out, exp.carry_bit);
      chk("cr0", cr0_out, ecr);
      apb(1'b0, OFF_FLAGS, 32'h0000_0000);
      chk("flags", rd, {24'h0, ecr, 3'h1, exp.carry_bit});
      apb(1'b0, OFF_AUXQ, 32'h0000_0000);
      chk("auxq_rd", rd, exp.aux_quotient);
    end
    prev = exp.dest;
    apb(1'b1, OFF_INSTR, 32'h7C00_0630);
    chk("bad_done", done_out, 32'h0000_0000);
    chk("bad_flag", illegal_out, 32'h0000_0001);
    chk("bad_dest", dest_reg_out, prev);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0000_0003);
    apb(1'b1, OFF_STATUS, 32'h0000_0003);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk("status_clr", rd, 32'h0000_0000);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    issue(32'h4321_8000, 32'h0000_0003, 32'h7C00_0730);
    chk("off_done", done_out, 32'h0000_0000);
    chk("off_dest", dest_reg_out, prev);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    apb(1'b1, OFF_INSTR, 32'h7C00_0730);
    chk("on_dest", dest_reg_out, exp.dest);
    // Mid-run reset must clear the destination, the illegal flag and field 0, and reload control
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk("rst_dest", dest_reg_out, 32'h0000_0000);
    chk("rst_illegal", illegal_out, 32'h0000_0000);
    chk("rst_cr0", cr0_out, 32'h0000_0000);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk("rst_ctrl", rd, CTRL_RESET);
    end_sim();
  end
endmodule
